//--- common/cbcs_pkg.sv
/*
  Shared constants and types of the CPU bus cycle sequencer: widths,
  status line codes, byte lane positions, wait state counts and the
  state and cycle enumerations.
  Assumes nothing beyond a SystemVerilog compiler; nothing is imported.
*/
package cbcs_pkg;

  localparam int unsigned BUS_W  = 16;
  localparam int unsigned STAT_W = 4;
  localparam int unsigned BYTE_W = 8;

  // Byte lanes of the multiplexed bus: even address on the upper half.
  localparam int unsigned HI_MSB = 15;
  localparam int unsigned HI_LSB = 8;
  localparam int unsigned LO_MSB = 7;
  localparam int unsigned LO_LSB = 0;
  localparam int unsigned ADDR_LSB = 0;

  // Status line codes; one code for each kind of cycle.
  localparam logic [3:0] STATUS_IDLE      = 4'h0;
  localparam logic [3:0] STATUS_IO_NORMAL = 4'h1;
  localparam logic [3:0] STATUS_IO_SPEC   = 4'h2;
  localparam logic [3:0] STATUS_OPERAND   = 4'h3;
  localparam logic [3:0] STATUS_STACK     = 4'h4;
  localparam logic [3:0] STATUS_FETCH1    = 4'h5;
  localparam logic [3:0] STATUS_FETCHN    = 4'h6;
  localparam logic [3:0] STATUS_ACK_NMI   = 4'h7;
  localparam logic [3:0] STATUS_ACK_VI    = 4'h8;
  localparam logic [3:0] STATUS_ACK_NVI   = 4'h9;

  // Automatic waits of the acknowledge cycle, before and with data strobe.
  localparam logic [1:0] ACK_PRE_WAITS  = 2'h3;
  localparam logic [1:0] ACK_POST_WAITS = 2'h2;
  localparam logic [1:0] AUTO_FIRST     = 2'h1;

  // Reset level of the synchronised pins: wait and requests inactive high.
  localparam logic [3:0] PIN_RESET = 4'hF;

  typedef enum logic [2:0] {
    REQ_IO_NORMAL,
    REQ_IO_SPECIAL,
    REQ_MEM_OPERAND,
    REQ_MEM_STACK,
    REQ_FETCH_FIRST,
    REQ_FETCH_NEXT
  } cbcs_req_e;

  typedef enum logic [1:0] {
    CYC_IO,
    CYC_MEM,
    CYC_ACK
  } cbcs_cyc_e;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_T1,
    ST_T2,
    ST_TWA,
    ST_TW,
    ST_T3,
    ST_T4,
    ST_T5
  } cbcs_state_e;

endpackage

//--- core/cbcs_pin_sync.sv
/*
  Three-flop input synchroniser for a group of pins; the output changes
  only once the second and third stages agree.
  Assumes the pins are asynchronous to ref_clk and may glitch.
*/
`timescale 1ns/1ps
module cbcs_pin_sync #(
  parameter int unsigned WIDTH     = 4,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // The first stage feeds only the second; per bit, agreement of the
  // later two filters a single-cycle disagreement.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= RESET_VALUE;
      stage2_reg <= RESET_VALUE;
      stage3_reg <= RESET_VALUE;
      pin_sync   <= RESET_VALUE;
    end else begin
      stage1_reg <= pin_async;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      pin_sync   <= (stage2_reg & stage3_reg) |
                    (pin_sync & (stage2_reg ^ stage3_reg));
    end
  end

endmodule // cbcs_pin_sync

//--- core/cbcs_sequencer.sv
/*
  Bus cycle sequencer: runs I/O, memory and interrupt acknowledge cycles
  on the multiplexed address/data bus, with wait states and interrupt
  sampling.
  Assumes a core on the user side that issues one request at a time and
  external logic that decodes the status code and strobes.
*/
// Overview of operation
// - I/O cycle: T1, T2, one auto wait, T3.
// - I/O waits repeat while wait is low.
// - I/O start: status code, strobe, port address.
// - I/O only in system mode; space low.
// - I/O input: float bus, strobe, capture in T3.
// - Byte input: even upper half, odd lower.
// - I/O output: drive data, byte on both halves.
// - Four distinct memory status codes.
// - Fetches are word reads; words use even addresses.
// - Memory cycle three states, waits after T2.
// - Memory T1: status, strobe, space, memory request.
// - Memory read: address, then float with strobe.
// - Byte read picks half from the lowest address bit.
// - Memory write: data replaces address, byte duplicated.
// - Three ack codes; edge latch; enables gate.
// - Sample requests in T3 of instruction end.
// - Dummy first fetch, PC held, stack decremented.
// - Ack cycle ten states, fixed pin levels.
// - Ack waits: three, strobe, two, extendable.
// - Edge latch clears as strobe rises in ack.
`timescale 1ns/1ps
module cbcs_sequencer (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic                  req_valid,
  input  wire cbcs_pkg::cbcs_req_e   req_kind,
  input  wire logic                  req_write,
  input  wire logic                  req_byte,
  input  wire logic                  req_last,
  input  wire logic [15:0]           req_addr,
  input  wire logic [15:0]           req_wdata,
  input  wire logic [15:0]           program_counter,
  input  wire logic                  fcw_system_mode,
  input  wire logic                  vectored_irq_enable,
  input  wire logic                  nonvectored_irq_enable,
  input  wire logic                  wait_n,
  input  wire logic                  nmi_n,
  input  wire logic                  vectored_irq_n,
  input  wire logic                  nonvectored_irq_n,
  input  wire logic [15:0]           muxed_addr_data_bus_in,
  output logic                       req_ready,
  output logic                       resp_valid,
  output logic                       resp_fault,
  output logic [15:0]                resp_rdata,
  output logic                       ack_done,
  output logic [3:0]                 ack_status,
  output logic [15:0]                ack_ident,
  output logic                       pc_hold,
  output logic                       ssp_decrement,
  output logic [15:0]                muxed_addr_data_bus_out,
  output logic                       muxed_addr_data_bus_oe,
  output logic                       address_strobe_n,
  output logic                       data_strobe_n,
  output logic                       memory_request_n,
  output logic [3:0]                 cycle_status_code,
  output logic                       read_write,
  output logic                       byte_word,
  output logic                       normal_system
);

  cbcs_pkg::cbcs_state_e state_reg, state_next;
  cbcs_pkg::cbcs_cyc_e   kind_reg, kind_next;
  logic [1:0]  auto_reg, auto_next;
  logic        phase_reg, phase_next;
  logic [3:0]  stat_reg, stat_next;
  logic        write_reg, write_next, byte_reg, byte_next;
  logic        last_reg, last_next, dummy_reg, dummy_next;
  logic [15:0] addr_reg, addr_next, wdata_reg, wdata_next;
  logic        pend_reg, pend_next, dummy_done_reg, dummy_done_next;
  logic [3:0]  pend_stat_reg, pend_stat_next;
  logic        nmi_latch_reg, nmi_latch_next, nmi_prev_reg;
  logic        save_mode_reg, save_mode_next;
  logic [3:0]  pins_s;
  logic        wait_ok, nmi_s, vi_s, nvi_s;

  // Pins from outside the clock domain.
  cbcs_pin_sync #(
    .WIDTH       (4),
    .RESET_VALUE (cbcs_pkg::PIN_RESET)
  ) u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .pin_async ({wait_n, nmi_n, vectored_irq_n, nonvectored_irq_n}),
    .pin_sync  (pins_s)
  );
  assign wait_ok = pins_s[3];
  assign nmi_s   = pins_s[2];
  assign vi_s    = pins_s[1];
  assign nvi_s   = pins_s[0];

  // Request decode; an I/O request outside system mode is refused.
  wire take     = (state_reg == cbcs_pkg::ST_IDLE) && req_valid && req_ready;
  wire req_io   = (req_kind == cbcs_pkg::REQ_IO_NORMAL) ||
                  (req_kind == cbcs_pkg::REQ_IO_SPECIAL);
  wire req_fetch = (req_kind == cbcs_pkg::REQ_FETCH_FIRST) ||
                   (req_kind == cbcs_pkg::REQ_FETCH_NEXT);
  wire fault    = take && req_io && !fcw_system_mode;
  wire start_ack   = (state_reg == cbcs_pkg::ST_IDLE) && pend_reg &&
                     dummy_done_reg;
  wire start_dummy = (state_reg == cbcs_pkg::ST_IDLE) && pend_reg &&
                     !dummy_done_reg;
  wire start_req   = take && !fault;
  wire start       = start_ack || start_dummy || start_req;
  wire [15:0] word_addr = {req_addr[15:1], 1'b0};

  // Status code chosen for each request kind.
  logic [3:0] req_stat;
  always_comb begin
    unique case (req_kind)
      cbcs_pkg::REQ_IO_NORMAL:   req_stat = cbcs_pkg::STATUS_IO_NORMAL;
      cbcs_pkg::REQ_IO_SPECIAL:  req_stat = cbcs_pkg::STATUS_IO_SPEC;
      cbcs_pkg::REQ_MEM_OPERAND: req_stat = cbcs_pkg::STATUS_OPERAND;
      cbcs_pkg::REQ_MEM_STACK:   req_stat = cbcs_pkg::STATUS_STACK;
      cbcs_pkg::REQ_FETCH_FIRST: req_stat = cbcs_pkg::STATUS_FETCH1;
      cbcs_pkg::REQ_FETCH_NEXT:  req_stat = cbcs_pkg::STATUS_FETCHN;
      default:                   req_stat = cbcs_pkg::STATUS_IDLE;
    endcase
  end

  // Cycle record loaded at the start of each cycle; fetches are words.
  assign kind_next  = start_ack ? cbcs_pkg::CYC_ACK :
                      start_dummy ? cbcs_pkg::CYC_MEM :
                      start_req ? (req_io ? cbcs_pkg::CYC_IO :
                                   cbcs_pkg::CYC_MEM) : kind_reg;
  assign stat_next  = start_ack ? pend_stat_reg :
                      start_dummy ? cbcs_pkg::STATUS_FETCH1 :
                      start_req ? req_stat : stat_reg;
  assign write_next = start ? (start_req && !req_fetch && req_write)
                            : write_reg;
  assign byte_next  = start ? (start_req && !req_fetch && req_byte)
                            : byte_reg;
  assign addr_next  = start_dummy ? program_counter :
                      start_ack ? '0 :
                      start_req ? ((byte_next || req_io) ? req_addr
                                                         : word_addr)
                                : addr_reg;
  assign wdata_next = start_req ? (req_byte ?
                        {req_wdata[cbcs_pkg::LO_MSB:cbcs_pkg::LO_LSB],
                         req_wdata[cbcs_pkg::LO_MSB:cbcs_pkg::LO_LSB]}
                        : req_wdata) : wdata_reg;
  assign last_next  = start ? (start_req && req_last) : last_reg;
  assign dummy_next = start ? start_dummy : dummy_reg;

  // Wait-state sequencing; wait_ok is the synchronised wait level.
  always_comb begin
    state_next = state_reg;
    auto_next  = auto_reg;
    phase_next = phase_reg;
    unique case (state_reg)
      cbcs_pkg::ST_IDLE: if (start) state_next = cbcs_pkg::ST_T1;
      cbcs_pkg::ST_T1: state_next = cbcs_pkg::ST_T2;
      cbcs_pkg::ST_T2: begin
        if (kind_reg == cbcs_pkg::CYC_MEM) begin
          state_next = wait_ok ? cbcs_pkg::ST_T3 : cbcs_pkg::ST_TW;
        end else begin
          state_next = cbcs_pkg::ST_TWA;
          auto_next  = cbcs_pkg::AUTO_FIRST;
          phase_next = 1'b0;
        end
      end
      cbcs_pkg::ST_TWA: begin
        if (kind_reg == cbcs_pkg::CYC_IO) begin
          state_next = wait_ok ? cbcs_pkg::ST_T3 : cbcs_pkg::ST_TW;
        end else if (auto_reg != (phase_reg ? cbcs_pkg::ACK_POST_WAITS
                                            : cbcs_pkg::ACK_PRE_WAITS)) begin
          auto_next = auto_reg + 2'h1;
        end else if (!wait_ok) begin
          state_next = cbcs_pkg::ST_TW;
        end else if (!phase_reg) begin
          phase_next = 1'b1;
          auto_next  = cbcs_pkg::AUTO_FIRST;
        end else begin
          state_next = cbcs_pkg::ST_T3;
        end
      end
      cbcs_pkg::ST_TW: begin
        if (wait_ok) begin
          if ((kind_reg == cbcs_pkg::CYC_ACK) && !phase_reg) begin
            state_next = cbcs_pkg::ST_TWA;
            phase_next = 1'b1;
            auto_next  = cbcs_pkg::AUTO_FIRST;
          end else begin
            state_next = cbcs_pkg::ST_T3;
          end
        end
      end
      cbcs_pkg::ST_T3: state_next = (kind_reg == cbcs_pkg::CYC_ACK) ?
                                    cbcs_pkg::ST_T4 : cbcs_pkg::ST_IDLE;
      cbcs_pkg::ST_T4: state_next = cbcs_pkg::ST_T5;
      cbcs_pkg::ST_T5: state_next = cbcs_pkg::ST_IDLE;
    endcase
  end

  // Interrupt sampling at T3 of an instruction's last cycle; NMI first.
  wire nmi_edge = nmi_prev_reg && !nmi_s;
  wire vi_req   = !vi_s && vectored_irq_enable;
  wire nvi_req  = !nvi_s && nonvectored_irq_enable;
  wire sample   = (state_reg == cbcs_pkg::ST_T3) &&
                  (kind_reg != cbcs_pkg::CYC_ACK) && last_reg && !dummy_reg;
  wire any_irq  = nmi_latch_reg || vi_req || nvi_req;
  wire ack_as_rise = (state_reg == cbcs_pkg::ST_T1) &&
                     (kind_reg == cbcs_pkg::CYC_ACK);
  wire dummy_end = (state_reg == cbcs_pkg::ST_T3) && dummy_reg;
  wire ack_end   = state_reg == cbcs_pkg::ST_T5;

  assign pend_next = (sample && any_irq) || (pend_reg && !start_ack);
  assign pend_stat_next = !(sample && any_irq) ? pend_stat_reg :
                          nmi_latch_reg ? cbcs_pkg::STATUS_ACK_NMI :
                          vi_req ? cbcs_pkg::STATUS_ACK_VI :
                          cbcs_pkg::STATUS_ACK_NVI;
  assign dummy_done_next = dummy_end || (dummy_done_reg && !start_ack);
  // A new edge in the clearing cycle is kept: the set wins.
  assign nmi_latch_next = nmi_edge || (nmi_latch_reg && !ack_as_rise);
  assign save_mode_next = ack_end || (save_mode_reg && !(start_req &&
                          (req_kind == cbcs_pkg::REQ_FETCH_FIRST)));

  // Pin values for the coming state, so that every pin is a flip-flop.
  wire act_n   = state_next != cbcs_pkg::ST_IDLE;
  wire mid_n   = (state_next == cbcs_pkg::ST_T2) ||
                 (state_next == cbcs_pkg::ST_TWA) ||
                 (state_next == cbcs_pkg::ST_TW);
  wire is_ack  = kind_next == cbcs_pkg::CYC_ACK;
  wire ds_n    = is_ack ? !(phase_next && (state_next == cbcs_pkg::ST_TWA ||
                  state_next == cbcs_pkg::ST_TW)) : !mid_n;
  wire t1_n    = state_next == cbcs_pkg::ST_T1;
  wire drv_dat = !is_ack && write_next &&
                 (mid_n || state_next == cbcs_pkg::ST_T3);
  wire ns_val  = start ? ((kind_next == cbcs_pkg::CYC_IO) ? 1'b0 :
                 is_ack ? normal_system :
                 !(fcw_system_mode || save_mode_reg || start_dummy))
                 : normal_system;
  wire capture = (state_next == cbcs_pkg::ST_T3) &&
                 (state_reg != cbcs_pkg::ST_T3) && !write_reg;
  wire [15:0] bus_byte = addr_reg[cbcs_pkg::ADDR_LSB] ?
    {8'h00, muxed_addr_data_bus_in[cbcs_pkg::LO_MSB:cbcs_pkg::LO_LSB]} :
    {8'h00, muxed_addr_data_bus_in[cbcs_pkg::HI_MSB:cbcs_pkg::HI_LSB]};
  wire [15:0] rd_val = byte_reg ? bus_byte : muxed_addr_data_bus_in;

  // Sequencer state and cycle record.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= cbcs_pkg::ST_IDLE;
      kind_reg  <= cbcs_pkg::CYC_MEM;
      auto_reg  <= '0;
      phase_reg <= 1'b0;
      stat_reg  <= cbcs_pkg::STATUS_IDLE;
      {write_reg, byte_reg, last_reg, dummy_reg} <= '0;
      addr_reg  <= '0;
      wdata_reg <= '0;
      {pend_reg, dummy_done_reg, save_mode_reg} <= '0;
      pend_stat_reg <= cbcs_pkg::STATUS_IDLE;
      nmi_latch_reg <= 1'b0;
      nmi_prev_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      kind_reg  <= kind_next;
      auto_reg  <= auto_next;
      phase_reg <= phase_next;
      stat_reg  <= stat_next;
      {write_reg, byte_reg, last_reg, dummy_reg} <=
        {write_next, byte_next, last_next, dummy_next};
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      {pend_reg, dummy_done_reg, save_mode_reg} <=
        {pend_next, dummy_done_next, save_mode_next};
      pend_stat_reg <= pend_stat_next;
      nmi_latch_reg <= nmi_latch_next;
      nmi_prev_reg  <= nmi_s;
    end
  end

  // Bus pins; idle leaves strobes high and the bus floating.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      address_strobe_n  <= 1'b1;
      data_strobe_n     <= 1'b1;
      memory_request_n  <= 1'b1;
      cycle_status_code <= cbcs_pkg::STATUS_IDLE;
      read_write        <= 1'b1;
      byte_word         <= 1'b0;
      normal_system     <= 1'b0;
      muxed_addr_data_bus_oe  <= 1'b0;
      muxed_addr_data_bus_out <= '0;
    end else begin
      address_strobe_n  <= !t1_n;
      data_strobe_n     <= ds_n;
      memory_request_n  <= !(act_n && kind_next == cbcs_pkg::CYC_MEM);
      cycle_status_code <= act_n ? stat_next : cbcs_pkg::STATUS_IDLE;
      read_write        <= !(act_n && !is_ack && write_next);
      byte_word         <= act_n && !is_ack && byte_next;
      normal_system     <= ns_val;
      muxed_addr_data_bus_oe  <= t1_n || drv_dat;
      muxed_addr_data_bus_out <= t1_n ? addr_next : wdata_next;
    end
  end

  // Results to the core; one-cycle pulses except held data, req_ready and pc_hold.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      req_ready  <= 1'b0;
      {resp_valid, resp_fault, ack_done} <= '0;
      resp_rdata <= '0;
      ack_status <= cbcs_pkg::STATUS_IDLE;
      ack_ident  <= '0;
      pc_hold    <= 1'b0;
      ssp_decrement <= 1'b0;
    end else begin
      req_ready  <= (state_next == cbcs_pkg::ST_IDLE) && !pend_next;
      resp_valid <= fault || ((state_reg == cbcs_pkg::ST_T3) &&
                    (kind_reg != cbcs_pkg::CYC_ACK) && !dummy_reg);
      resp_fault <= fault;
      ack_done   <= ack_end;
      if (capture && kind_reg != cbcs_pkg::CYC_ACK) resp_rdata <= rd_val;
      if (capture && kind_reg == cbcs_pkg::CYC_ACK) ack_ident <= rd_val;
      if (start_ack) ack_status <= pend_stat_reg;
      pc_hold       <= dummy_next && act_n;
      ssp_decrement <= start_dummy;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_io_auto_wait: assert property (
    state_reg == cbcs_pkg::ST_T2 && kind_reg == cbcs_pkg::CYC_IO
    |=> state_reg == cbcs_pkg::ST_TWA)
    else $error("I/O cycle skipped its automatic wait state.");
  a_io_wait_ext: assert property (
    (state_reg == cbcs_pkg::ST_TWA || state_reg == cbcs_pkg::ST_TW) &&
    kind_reg == cbcs_pkg::CYC_IO && !wait_ok |=> state_reg == cbcs_pkg::ST_TW)
    else $error("I/O wait state not added while wait low.");
  a_io_space_low: assert property (
    state_reg != cbcs_pkg::ST_IDLE && kind_reg == cbcs_pkg::CYC_IO
    |-> !normal_system && memory_request_n)
    else $error("I/O cycle with wrong space or memory request.");
  a_mem_three: assert property (
    state_reg == cbcs_pkg::ST_T1 && kind_reg == cbcs_pkg::CYC_MEM ##1
    wait_ok |=> state_reg == cbcs_pkg::ST_T3 ##1
    state_reg == cbcs_pkg::ST_IDLE)
    else $error("Memory cycle without wait not three states.");
  a_as_start: assert property (
    $fell(address_strobe_n) |-> state_reg == cbcs_pkg::ST_T1 ##1
    address_strobe_n)
    else $error("Address strobe not a one-state pulse in T1.");
  a_byte_dup: assert property (
    muxed_addr_data_bus_oe && byte_word && !read_write &&
    state_reg == cbcs_pkg::ST_T2 |-> muxed_addr_data_bus_out[15:8] ==
    muxed_addr_data_bus_out[7:0])
    else $error("Byte write not on both bus halves.");
  a_word_even: assert property (
    !address_strobe_n && !byte_word && kind_reg == cbcs_pkg::CYC_MEM
    |-> !muxed_addr_data_bus_out[0])
    else $error("Word access at an odd address.");
  a_ack_waits: assert property (
    state_reg == cbcs_pkg::ST_T2 && kind_reg == cbcs_pkg::CYC_ACK |=>
    (state_reg == cbcs_pkg::ST_TWA && data_strobe_n) [*3])
    else $error("Acknowledge lacks three waits before data strobe.");
  a_nmi_clear: assert property (
    ack_as_rise && !nmi_edge |=> !nmi_latch_reg)
    else $error("Edge latch not cleared as strobe rose.");
  a_read_float: assert property (
    state_reg == cbcs_pkg::ST_T2 && read_write &&
    kind_reg != cbcs_pkg::CYC_ACK |-> !muxed_addr_data_bus_oe &&
    !data_strobe_n)
    else $error("Read T2 without floated bus and low data strobe.");

endmodule // cbcs_sequencer

//--- test/cbcs_far_side.sv
/*
  Far-side model: memory, ports and an interrupting device on the bus.
  Assumes the sequencer's pins; the bench decides when wait is held low.
*/
`timescale 1ns/1ps
module cbcs_far_side (
  input  wire logic        ref_clk,
  input  wire logic        data_strobe_n,
  input  wire logic        read_write,
  input  wire logic        bus_oe,
  input  wire logic [15:0] bus_out,
  input  wire logic [15:0] rd_data,
  input  wire logic        hold_wait,
  output logic      [15:0] bus_in,
  output logic             wait_n
);
  logic        drive;
  logic [15:0] last_q = 16'h0000;
  // Whole words go out on a strobed read, whatever the lowest bit; a
  // released bus shows a changing pattern so stale data cannot pass.
  assign drive  = !data_strobe_n && read_write && !bus_oe;
  assign bus_in = drive ? rd_data : (bus_oe ? bus_out : ~last_q);
  assign wait_n = !hold_wait;
  // Track the wire level seen last.
  always @(posedge ref_clk) begin
    last_q <= bus_in;
  end
endmodule // cbcs_far_side

//--- test/testbench.sv
/*
  Self-checking bench of the bus cycle sequencer with its far side.
  Assumes the package codes; inputs change at the falling clock edge.
*/
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0, rst = 1'b1, req_valid = 1'b0, req_write = 1'b0;
  logic req_byte = 1'b0, req_last = 1'b0, fcw_system_mode = 1'b1;
  logic vectored_irq_enable = 1'b1, nonvectored_irq_enable = 1'b1;
  logic nmi_n = 1'b1, vectored_irq_n = 1'b1, nonvectored_irq_n = 1'b1;
  logic wait_n, hold_wait = 1'b0, req_ready, resp_valid, resp_fault;
  logic ack_done, pc_hold, ssp_decrement, muxed_addr_data_bus_oe;
  logic address_strobe_n, data_strobe_n, memory_request_n, read_write;
  logic byte_word, normal_system, rw, bw, ns, mr, got, dec;
  logic [3:0]  ack_status, cycle_status_code, st, fst;
  logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, resp_rdata;
  logic [15:0] program_counter = 16'h0200, rd_data = 16'hA55A;
  logic [15:0] ack_ident, muxed_addr_data_bus_in, muxed_addr_data_bus_out;
  logic [15:0] ad, wd, fad;
  cbcs_pkg::cbcs_req_e req_kind = cbcs_pkg::REQ_MEM_OPERAND;
  int err_count = 0, tests_run = 0, len = 0;
  // Free-running 40 MHz clock.
  always #12.5 ref_clk = ~ref_clk;
  cbcs_sequencer cbcs_sequencer_inst (.ref_clk, .rst, .req_valid,
    .req_kind, .req_write, .req_byte, .req_last, .req_addr, .req_wdata,
    .program_counter, .fcw_system_mode, .vectored_irq_enable,
    .nonvectored_irq_enable, .wait_n, .nmi_n, .vectored_irq_n,
    .nonvectored_irq_n, .muxed_addr_data_bus_in, .req_ready, .resp_valid,
    .resp_fault, .resp_rdata, .ack_done, .ack_status, .ack_ident,
    .pc_hold, .ssp_decrement, .muxed_addr_data_bus_out,
    .muxed_addr_data_bus_oe, .address_strobe_n, .data_strobe_n,
    .memory_request_n, .cycle_status_code, .read_write, .byte_word,
    .normal_system);
  cbcs_far_side cbcs_far_side_inst (.ref_clk, .data_strobe_n,
    .read_write, .bus_oe(muxed_addr_data_bus_oe), .rd_data, .hold_wait,
    .bus_out(muxed_addr_data_bus_out), .bus_in(muxed_addr_data_bus_in),
    .wait_n);
  // Compare and count; case inequality lets no unknown pass.
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Present one request and hold it until the edge that takes it.
  task automatic issue(input cbcs_pkg::cbcs_req_e k, input logic w, b,
                       input logic l, input logic [15:0] a, d);
    int n;
    req_kind = k;
    {req_write, req_byte, req_last} = {w, b, l};
    {req_addr, req_wdata, req_valid} = {a, d, 1'b1};
    for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge ref_clk);
    @(negedge ref_clk);
    req_valid = 1'b0;
  endtask
  // Follow the pins until the answer or the limit runs out. An answer
  // already standing as the task starts, as a refusal does, is caught.
  task automatic watch(input int lim, input logic for_ack);
    int n;
    {got, dec, fst} = 6'h00;
    got = for_ack ? (ack_done === 1'b1) : (resp_valid === 1'b1);
    for (n = 0; n < lim && !got; n++) begin
      if (address_strobe_n === 1'b0) begin
        {st, ad, len} = {cycle_status_code, muxed_addr_data_bus_out, 32'h0};
        {rw, bw, ns, mr} = {read_write, byte_word, normal_system,
                            memory_request_n};
        if (fst === 4'h0) {fst, fad} = {st, ad};
      end
      len++;
      if (!data_strobe_n && muxed_addr_data_bus_oe) wd = muxed_addr_data_bus_out;
      dec |= (ssp_decrement === 1'b1) && (pc_hold === 1'b1);
      @(negedge ref_clk);
      got = for_ack ? (ack_done === 1'b1) : (resp_valid === 1'b1);
    end
  endtask
  // Memory reads and a byte write, with lane choice and cycle length.
  task automatic t_mem;
    issue(cbcs_pkg::REQ_MEM_OPERAND, 0, 0, 0, 16'h0100, 0);
    watch(20, 0);
    cmp({st, rw, bw, mr, resp_rdata}, {cbcs_pkg::STATUS_OPERAND, 3'b100, rd_data});
    cmp({16'(len), ad}, {16'h3, 16'h0100});
    issue(cbcs_pkg::REQ_MEM_STACK, 0, 1, 0, 16'h0101, 0);
    watch(20, 0);
    cmp({st, bw, resp_rdata}, {cbcs_pkg::STATUS_STACK, 17'h1005A});
    issue(cbcs_pkg::REQ_FETCH_NEXT, 1, 1, 0, 16'h0103, 16'h1234);
    watch(20, 0);
    cmp({st, rw, bw, ad}, {cbcs_pkg::STATUS_FETCHN, 18'h20102});
    issue(cbcs_pkg::REQ_MEM_OPERAND, 1, 1, 0, 16'h0105, 16'h003C);
    watch(20, 0);
    cmp({rw, mr, wd}, {2'b00, 16'h3C3C});
    $display("test mem done");
  endtask
  // Refusal outside system mode, held wait, byte lanes on ports.
  task automatic t_io;
    fcw_system_mode = 1'b0;
    issue(cbcs_pkg::REQ_IO_NORMAL, 0, 0, 0, 16'h0010, 0);
    watch(20, 0);
    cmp({got, resp_fault}, 2'b11);
    {fcw_system_mode, hold_wait} = 2'b11;
    repeat (4) @(negedge ref_clk);
    issue(cbcs_pkg::REQ_IO_SPECIAL, 0, 1, 0, 16'h0010, 0);
    watch(30, 0);
    cmp(got, 0);
    hold_wait = 1'b0;
    watch(30, 0);
    cmp({got, resp_rdata}, {1'b1, 16'h00A5});
    cmp({st, rw, bw, ns, mr, ad}, {cbcs_pkg::STATUS_IO_SPEC, 20'hD0010});
    issue(cbcs_pkg::REQ_IO_NORMAL, 1, 1, 0, 16'h0013, 16'h0077);
    watch(20, 0);
    cmp({13'(len), rw, bw, mr, wd}, {13'h4, 3'b011, 16'h7777});
    cmp(ad[0] ? wd[7:0] : wd[15:8], 8'h77);
    $display("test io done");
  endtask
  // One acknowledge: s picks the request line, code the expected status.
  task automatic t_irq(input int s, input logic [3:0] code);
    {nmi_n, vectored_irq_n, nonvectored_irq_n} = ~(3'b100 >> s);
    repeat (8) @(negedge ref_clk);
    nmi_n = 1'b1;
    issue(cbcs_pkg::REQ_MEM_OPERAND, 0, 0, 1, 16'h0100, 0);
    watch(20, 0);
    watch(90, 1);
    {vectored_irq_n, nonvectored_irq_n} = 2'b11;
    cmp({ack_status, st, mr, rw, bw, 4'(len)}, {code, code, 7'h6A});
    cmp({got, dec, fst, fad}, {2'b11, cbcs_pkg::STATUS_FETCH1, program_counter});
    cmp(ack_ident, rd_data);
  endtask
  // All three acknowledge codes, then a masked line and a cleared latch.
  task automatic t_ack;
    t_irq(0, cbcs_pkg::STATUS_ACK_NMI);
    t_irq(1, cbcs_pkg::STATUS_ACK_VI);
    t_irq(2, cbcs_pkg::STATUS_ACK_NVI);
    {vectored_irq_enable, vectored_irq_n} = 2'b00;
    repeat (8) @(negedge ref_clk);
    issue(cbcs_pkg::REQ_MEM_OPERAND, 0, 0, 1, 16'h0100, 0);
    watch(20, 0);
    watch(40, 1);
    cmp(got, 0);
    {vectored_irq_enable, vectored_irq_n} = 2'b11;
    $display("test ack done");
  endtask
  // Print the counts and the verdict, then stop.
  task automatic end_sim;
    $display("tests_run %0d err_count %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence after a reset of 16 cycles.
  initial begin
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    t_mem;
    t_io;
    t_ack;
    end_sim;
  end
  // Watchdog, far beyond the roughly 250 cycles the tests need.
  initial begin
    #100000;
    err_count++;
    end_sim;
  end
endmodule // testbench
